// ===== nvs_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// CPU data bus and debug port stand-in
module nvs_cpu_model (
  input  wire logic        clk,
  input  wire logic        mem_wait,
  output logic             mem_req,
  output logic             mem_we,
  output logic             mem_ee,
  output logic [23:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             instr_done,
  output logic             dbg_cmd_valid,
  output logic [6:0]       dbg_cmd
);
  int stall;
  initial begin
    mem_req = 1'b0;
    mem_we = 1'b0;
    mem_ee = 1'b0;
    mem_addr = 24'h0;
    mem_wdata = 8'h0;
    instr_done = 1'b0;
    dbg_cmd_valid = 1'b0;
    dbg_cmd = 7'h0;
  end
  task automatic store(input logic ee, input logic [23:0] a, input logic [7:0] d);
    logic w;
    @(posedge clk);
    mem_req <= 1'b1;
    mem_we <= 1'b1;
    mem_ee <= ee;
    mem_addr <= a;
    mem_wdata <= d;
    stall = 0;
    forever begin
      @(posedge clk);
      w = mem_wait;
      if (!w) break;
      stall++;
    end
    // Released lines show garbage, not the last value
    mem_req <= 1'b0;
    mem_we <= 1'b0;
    mem_addr <= ~a;
    mem_wdata <= ~d;
  endtask : store
  task automatic dbg(input logic [6:0] c);
    @(posedge clk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd <= c;
    @(posedge clk);
    dbg_cmd_valid <= 1'b0;
    dbg_cmd <= ~c;
  endtask : dbg
  task automatic instr(input int n);
    repeat (n) begin
      @(posedge clk);
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
    end
  endtask : instr
endmodule : nvs_cpu_model
`default_nettype wire

// ===== nvs_pkg.sv
// ==========================================================================
// Shared constants of the erase/write sequencer
package nvs_pkg;
  localparam int unsigned CLK_MHZ = 40;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRLA    = 6'h00;
  localparam logic [5:0] IDX_CTRLB    = 6'h01;
  localparam logic [5:0] IDX_CTRLC    = 6'h02;
  localparam logic [5:0] IDX_INTEN    = 6'h04;
  localparam logic [5:0] IDX_INTERRUPT_FLAG_REGISTER = 6'h05;
  localparam logic [5:0] IDX_STATUS   = 6'h06;
  localparam logic [5:0] IDX_KEY      = 6'h10;

  localparam logic [6:0] CTRLA_RST = 7'h00;
  localparam logic [7:0] CTRLB_RST = 8'h30;
  localparam logic [7:0] CTRLC_RST = 8'h00;

  localparam int unsigned INT_EE_BIT   = 0;
  localparam int unsigned INT_FL_BIT   = 1;
  localparam int unsigned STAT_ERR_LSB = 4;

  localparam logic [2:0] ERR_NONE      = 3'h0;
  localparam logic [2:0] ERR_COLLISION = 3'h1;
  localparam logic [2:0] ERR_SEQUENCE  = 3'h2;

  // Key values are arbitrary
  localparam logic [7:0] KEY_CMD    = 8'h5a;
  localparam logic [7:0] KEY_IO     = 8'ha5;
  localparam logic [2:0] KEY_WINDOW = 3'h4;

  localparam logic [6:0] CMD_NONE    = 7'h00;
  localparam logic [6:0] CMD_NOP     = 7'h01;
  localparam logic [6:0] CMD_FLPG    = 7'h08;
  localparam logic [6:0] CMD_FLPG32  = 7'h0d;
  localparam logic [6:0] CMD_EEWRITE = 7'h12;
  localparam logic [6:0] CMD_EEPROM_ERASE_WRITE_MODE  = 7'h13;
  localparam logic [6:0] CMD_EEPAGE  = 7'h17;
  localparam logic [6:0] CMD_EEBYTE  = 7'h18;
  localparam logic [6:0] CMD_EEBLK32 = 7'h1d;
  localparam logic [6:0] CMD_CHIP    = 7'h20;
  localparam logic [6:0] CMD_EEALL   = 7'h30;

  localparam logic [7:0] ERASED_BYTE = 8'hff;

  localparam int unsigned T_FL_ERASE_NS = 4000000;
  localparam int unsigned T_EE_OP_NS    = 2000000;
  localparam int unsigned T_EE_ERWR_NS  = 4000000;
  localparam int unsigned T_CHIP_NS     = 8000000;
  localparam int unsigned FL_ERASE_CYC  = T_FL_ERASE_NS * CLK_MHZ / 1000;
  localparam int unsigned EE_OP_CYC     = T_EE_OP_NS * CLK_MHZ / 1000;
  localparam int unsigned EE_ERWR_CYC   = T_EE_ERWR_NS * CLK_MHZ / 1000;
  localparam int unsigned CHIP_CYC      = T_CHIP_NS * CLK_MHZ / 1000;
endpackage : nvs_pkg

// ===== nvs_sequencer.sv
// Contract
// - Flash page erase: one store inside the page erases that page.
// - EEPROM page erase clears only buffered bytes; CPU keeps running.
// - Page buffer clears itself when the erase completes.
// - Flash multi-page erase ignores low 1..5 page bits, erases block.
// - EEPROM write mode: one byte per store, access while busy stalls.
// - Erase/write mode: each store erases then writes, stalls when busy.
// - Byte erase ignores store data; erased byte reads 0xff.
// - Multi-byte erase ignores low 1..5 address bits, erases block.
// - EEPROM access while busy gets bus wait-states until done.
// - Chip erase clears Flash and EEPROM unless preserve fuse set on an unlocked device.
// - Locked chip erase always clears EEPROM; protect bits do not block.
// - Chip erase is accepted only from the debug port.
// - Whole-EEPROM erase clears all bytes and halts the CPU throughout.
// - Chip erase leaves fuses and the brownout enable untouched.
// - Reset aborts any write in progress.
// - Ready flags set when Flash or EEPROM becomes ready.
// - Interrupt asserts while flag and enable set, until flag cleared.
// - Sleep is immediate when idle, else clocks stay until done.
// - Ready interrupt wakes only from idle sleep.
// - Protected registers change only within four instructions of key.
// - Command changes pass through no-command; busy select is collision.
// - Codes 0x08..0x0d Flash erases, 0x20 chip erase.
// - Codes 0x12, 0x13, 0x17..0x1d, 0x30 select EEPROM operations.
`timescale 1ns/1ps
`default_nettype none
module nvs_sequencer
  import nvs_pkg::*;
#(
  parameter int unsigned ADDR_W    = 24,
  parameter int unsigned FLASH_PAGE_NUMBER_LSB = 9,
  parameter int unsigned CNT_W     = 20,
  parameter int unsigned FL_CYC    = FL_ERASE_CYC,
  parameter int unsigned EE_CYC    = EE_OP_CYC,
  parameter int unsigned ERWR_CYC  = EE_ERWR_CYC,
  parameter int unsigned CHIP_ERASE_CMD_CYC  = CHIP_CYC
) (
  input  wire  logic              clk,
  input  wire  logic              rstn,
  input  wire  logic [7:0]        paddr,
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [31:0]       pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire  logic              instr_done,
  input  wire  logic              mem_req,
  input  wire  logic              mem_we,
  input  wire  logic              mem_ee,
  input  wire  logic [ADDR_W-1:0] mem_addr,
  input  wire  logic [7:0]        mem_wdata,
  output logic                    mem_wait,
  output logic                    cpu_halt,
  input  wire  logic              dbg_cmd_valid,
  input  wire  logic [6:0]        dbg_cmd,
  input  wire  logic              eeprom_preserve_fuse,
  input  wire  logic              device_locked,
  input  wire  logic              brownout_fuse_en,
  output logic                    brownout_en,
  input  wire  logic              sleep_req,
  input  wire  logic              sleep_idle,
  output logic                    nvm_clk_on,
  output logic                    nvm_sleeping,
  output logic                    irq,
  output logic                    wake_req,
  output logic                    flash_busy_flag,
  output logic                    eeprom_busy_flag,
  output logic                    op_start,
  output logic                    op_flash,
  output logic                    op_erase,
  output logic                    op_write,
  output logic                    op_all,
  output logic [ADDR_W-1:0]       op_addr,
  output logic [31:0]             op_mask,
  output logic [7:0]              op_data
);
  if (ADDR_W < FLASH_PAGE_NUMBER_LSB + 6 || CHIP_ERASE_CMD_CYC >= (1 << CNT_W) || FL_CYC >= (1 << CNT_W) ||
      ERWR_CYC >= (1 << CNT_W) || EE_CYC >= (1 << CNT_W) || EE_CYC == 0)
    $error("nvs_sequencer: unsupported parameters");

  typedef struct packed {
    logic [6:0]        cmd;
    logic [7:0]        ctrlb;
    logic [7:0]        ctrlc;
    logic [1:0]        inten;
    logic [1:0]        flags;
    logic [2:0]        err;
    logic              key_io;
    logic [2:0]        key_cnt;
    logic [CNT_W-1:0]  fl_cnt;
    logic [CNT_W-1:0]  ee_cnt;
    logic              ee_full;
    logic              ee_pg;
    logic [31:0]       ee_mask;
    logic [ADDR_W-1:0] ee_page;
    logic              op_start;
    logic              op_flash;
    logic              op_erase;
    logic              op_write;
    logic              op_all;
    logic [ADDR_W-1:0] op_addr;
    logic [31:0]       op_mask;
    logic [7:0]        op_data;
    logic [31:0]       prdata;
    logic              bod_en;
  } nvs_state_t;

  nvs_state_t q, d;

  logic fl_busy;
  logic ee_busy;
  logic apb_wr;
  logic cmd_idle;
  logic st_go;

  function automatic logic [ADDR_W-1:0] nvs_blk(input logic [2:0] span, input int base);
    logic [ADDR_W-1:0] one;
    one = {{(ADDR_W-1){1'b0}}, 1'b1};
    nvs_blk = ~((one << (base + int'(span))) - one);
  endfunction : nvs_blk

  // ========================================================================
  // Bus and CPU handshakes
  assign fl_busy  = q.fl_cnt != '0;
  assign ee_busy  = q.ee_cnt != '0;
  assign apb_wr   = psel & penable & pwrite;
  assign cmd_idle = (q.cmd == CMD_NONE) || (q.cmd == CMD_NOP);
  assign pready   = penable;
  assign pslverr  = psel & penable & !(paddr[7:2] inside {IDX_CTRLA, IDX_CTRLB, IDX_CTRLC,
                    IDX_INTEN, IDX_INTERRUPT_FLAG_REGISTER, IDX_STATUS, IDX_KEY});
  assign mem_wait = mem_req & (mem_ee ? ee_busy : fl_busy);
  assign st_go    = mem_req & mem_we & !mem_wait;
  assign cpu_halt = q.ee_full;
  // Level request from flag and enable
  assign irq      = |(q.flags & q.inten);
  // Only idle sleep may be woken
  assign wake_req = irq & sleep_req & sleep_idle;
  // Clocks held while an operation runs
  assign nvm_clk_on   = !sleep_req | fl_busy | ee_busy;
  assign nvm_sleeping = sleep_req & !fl_busy & !ee_busy;

  assign prdata           = q.prdata;
  assign flash_busy_flag  = fl_busy;
  assign eeprom_busy_flag = ee_busy;
  assign brownout_en      = q.bod_en;
  assign op_start = q.op_start;
  assign op_flash = q.op_flash;
  assign op_erase = q.op_erase;
  assign op_write = q.op_write;
  assign op_all   = q.op_all;
  assign op_addr  = q.op_addr;
  assign op_mask  = q.op_mask;
  assign op_data  = q.op_data;

  // ========================================================================
  // Next state
  always_comb begin
    logic [6:0] nc;
    logic [2:0] span;
    nc   = pwdata[6:0];
    span = '0;
    d = q;
    d.op_start = 1'b0;
    // Brownout enable follows the fuse only
    d.bod_en = brownout_fuse_en;
    if (fl_busy) begin
      d.fl_cnt = q.fl_cnt - 1'b1;
    end
    if (ee_busy) begin
      d.ee_cnt = q.ee_cnt - 1'b1;
    end
    if (q.ee_cnt == CNT_W'(1)) begin
      d.ee_full = 1'b0;
      if (q.ee_pg) begin
        d.ee_mask = '0;
        d.ee_pg   = 1'b0;
      end
    end
    if (q.key_cnt != '0 && instr_done) begin
      d.key_cnt = q.key_cnt - 1'b1;
    end
    if (psel & !penable) begin
      unique case (paddr[7:2])
        IDX_CTRLA:    d.prdata = {25'h0, q.cmd};
        IDX_CTRLB:    d.prdata = {24'h0, q.ctrlb};
        IDX_CTRLC:    d.prdata = {24'h0, q.ctrlc};
        IDX_INTEN:    d.prdata = {30'h0, q.inten};
        IDX_INTERRUPT_FLAG_REGISTER: d.prdata = {30'h0, q.flags};
        IDX_STATUS:   d.prdata = {25'h0, q.err, 2'b00, fl_busy, ee_busy};
        default:      d.prdata = '0;
      endcase
    end
    if (apb_wr) begin
      unique case (paddr[7:2])
        IDX_KEY: begin
          if (pwdata[7:0] == KEY_CMD || pwdata[7:0] == KEY_IO) begin
            d.key_io  = pwdata[7:0] == KEY_IO;
            d.key_cnt = KEY_WINDOW;
          end
        end
        IDX_CTRLA: begin
          if (q.key_cnt != '0 && !q.key_io) begin
            d.key_cnt = '0;
            if (nc == CMD_NONE || nc == CMD_NOP) begin
              d.cmd = nc;
            // Chip erase refused from the CPU
            end else if (nc == CMD_CHIP) begin
              d.cmd = q.cmd;
            end else if (fl_busy || ee_busy) begin
              d.err = ERR_COLLISION;
            end else if (!cmd_idle) begin
              d.err = ERR_SEQUENCE;
            end else begin
              d.cmd = nc;
              d.err = ERR_NONE;
              // Whole EEPROM erase starts on write
              if (nc == CMD_EEALL) begin
                d.ee_cnt   = CNT_W'(CHIP_ERASE_CMD_CYC);
                d.ee_full  = 1'b1;
                d.op_start = 1'b1;
                d.op_flash = 1'b0;
                d.op_erase = 1'b1;
                d.op_write = 1'b0;
                d.op_all   = 1'b1;
                d.op_data  = ERASED_BYTE;
              // Erase only buffered bytes, if any
              end else if (nc == CMD_EEPAGE && q.ee_mask != '0) begin
                d.ee_cnt   = CNT_W'(EE_CYC);
                d.ee_pg    = 1'b1;
                d.op_start = 1'b1;
                d.op_flash = 1'b0;
                d.op_erase = 1'b1;
                d.op_write = 1'b0;
                d.op_all   = 1'b0;
                d.op_addr  = q.ee_page;
                d.op_mask  = q.ee_mask;
                d.op_data  = ERASED_BYTE;
              end
            end
          end
        end
        IDX_CTRLB: begin
          if (q.key_cnt != '0 && q.key_io) begin
            d.ctrlb   = pwdata[7:0];
            d.key_cnt = '0;
          end
        end
        IDX_CTRLC: begin
          if (q.key_cnt != '0 && q.key_io) begin
            d.ctrlc   = pwdata[7:0];
            d.key_cnt = '0;
          end
        end
        IDX_INTEN:    d.inten = pwdata[1:0];
        IDX_INTERRUPT_FLAG_REGISTER: d.flags = q.flags & ~pwdata[1:0];
        default:      d.err = q.err;
      endcase
    end
    // Ready flags; set wins over clear
    if (q.fl_cnt == CNT_W'(1)) begin
      d.flags[INT_FL_BIT] = 1'b1;
    end
    if (q.ee_cnt == CNT_W'(1)) begin
      d.flags[INT_EE_BIT] = 1'b1;
    end
    if (st_go && !mem_ee && q.cmd >= CMD_FLPG && q.cmd <= CMD_FLPG32) begin
      span = 3'(q.cmd - CMD_FLPG);
      // Page or aligned page block erase
      d.fl_cnt   = CNT_W'(FL_CYC);
      d.op_start = 1'b1;
      d.op_flash = 1'b1;
      d.op_erase = 1'b1;
      d.op_write = 1'b0;
      d.op_all   = 1'b0;
      d.op_addr  = mem_addr & nvs_blk(span, int'(FLASH_PAGE_NUMBER_LSB));
      d.op_mask  = '1;
      d.op_data  = ERASED_BYTE;
    end else if (st_go && mem_ee) begin
      d.op_flash = 1'b0;
      d.op_all   = 1'b0;
      d.op_addr  = mem_addr;
      d.op_mask  = 32'h1;
      d.op_data  = mem_wdata;
      if (q.cmd == CMD_EEWRITE || q.cmd == CMD_EEPROM_ERASE_WRITE_MODE) begin
        d.ee_cnt   = CNT_W'(q.cmd == CMD_EEPROM_ERASE_WRITE_MODE ? ERWR_CYC : EE_CYC);
        d.op_start = 1'b1;
        d.op_erase = q.cmd == CMD_EEPROM_ERASE_WRITE_MODE;
        d.op_write = 1'b1;
      end else if (q.cmd >= CMD_EEBYTE && q.cmd <= CMD_EEBLK32) begin
        span = 3'(q.cmd - CMD_EEBYTE);
        d.ee_cnt   = CNT_W'(EE_CYC);
        d.op_start = 1'b1;
        d.op_erase = 1'b1;
        d.op_write = 1'b0;
        d.op_addr  = mem_addr & nvs_blk(span, 0);
        d.op_data  = ERASED_BYTE;
      end else if (cmd_idle) begin
        // Stores with no command fill the page buffer
        d.ee_page = mem_addr & nvs_blk(3'h5, 0);
        d.ee_mask = q.ee_mask | (32'h1 << mem_addr[4:0]);
      end
    end
    // Chip erase from the debug port only
    if (dbg_cmd_valid && dbg_cmd == CMD_CHIP && !fl_busy && !ee_busy) begin
      d.fl_cnt   = CNT_W'(CHIP_ERASE_CMD_CYC);
      d.ee_cnt   = (eeprom_preserve_fuse && !device_locked) ? '0 : CNT_W'(CHIP_ERASE_CMD_CYC);
      d.ee_mask  = '0;
      d.op_start = 1'b1;
      d.op_flash = 1'b1;
      d.op_erase = 1'b1;
      d.op_write = 1'b0;
      d.op_all   = 1'b1;
      d.op_addr  = '0;
      d.op_mask  = {31'h0, !(eeprom_preserve_fuse && !device_locked)};
      d.op_data  = ERASED_BYTE;
    end
  end

  // ========================================================================
  // State register
  // Reset drops every timer and aborts the operation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.cmd   <= CTRLA_RST;
      q.ctrlb <= CTRLB_RST;
      q.ctrlc <= CTRLC_RST;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ee_done;
    $fell(ee_busy);
  endsequence
  sequence s_fl_done;
    $fell(fl_busy);
  endsequence
  property p_ee_ready;
    s_ee_done |-> q.flags[INT_EE_BIT];
  endproperty
  a_ee_ready: assert property (p_ee_ready)
    else $error("eeprom ready flag not set");
  property p_fl_ready;
    s_fl_done |-> q.flags[INT_FL_BIT] && !(irq ^ |(q.flags & q.inten));
  endproperty
  a_fl_ready: assert property (p_fl_ready)
    else $error("flash ready flag not set");
  property p_irq_hold;
    q.flags[0] && q.inten[0] &&
      !(apb_wr && (paddr[7:2] == IDX_INTERRUPT_FLAG_REGISTER || paddr[7:2] == IDX_INTEN)) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped while flag set");
  property p_wait;
    mem_req && mem_ee && ee_busy |-> mem_wait ##1 (!ee_busy || !mem_req || mem_wait);
  endproperty
  a_wait: assert property (p_wait)
    else $error("eeprom access not stalled");
  property p_erase_ff;
    q.op_start && q.op_erase && !q.op_write |-> q.op_data == ERASED_BYTE;
  endproperty
  a_erase_ff: assert property (p_erase_ff)
    else $error("erase data not 0xff");
  property p_chip_dbg;
    q.op_start && q.op_flash && q.op_all |-> $past(dbg_cmd_valid) && $past(dbg_cmd) == CMD_CHIP;
  endproperty
  a_chip_dbg: assert property (p_chip_dbg)
    else $error("chip erase without debug command");
  property p_fl_align;
    q.op_start && q.op_flash && !q.op_all |-> q.op_addr[FLASH_PAGE_NUMBER_LSB-1:0] == '0;
  endproperty
  a_fl_align: assert property (p_fl_align)
    else $error("flash erase address not page aligned");
  property p_buf_clear;
    $rose(q.ee_pg) |-> q.ee_mask != '0 ##[1:1000] (q.ee_mask == '0 || !ee_busy);
  endproperty
  a_buf_clear: assert property (p_buf_clear)
    else $error("page buffer not cleared");
  property p_locked;
    apb_wr && paddr[7:2] == IDX_CTRLA && q.key_cnt == '0 |=> $stable(q.cmd);
  endproperty
  a_locked: assert property (p_locked)
    else $error("command changed without key");
  property p_sleep;
    sleep_req && (fl_busy || ee_busy) |-> nvm_clk_on && !nvm_sleeping;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("clocks stopped during operation");
  property p_halt;
    $rose(q.ee_full) |-> cpu_halt [*8];
  endproperty
  a_halt: assert property (p_halt)
    else $error("cpu not halted during eeprom erase");
endmodule : nvs_sequencer
`default_nettype wire

// ===== tb_nvm_erase_write_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_erase_write_sequencer
  import nvs_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, op_mask, rd, ca_mask, seed = 32'h3e;
  logic pready, pslverr, mem_wait, cpu_halt, brownout_en, nvm_clk_on, nvm_sleeping, rd_err;
  logic irq, wake_req, flash_busy_flag, eeprom_busy_flag, op_start, op_flash, op_erase;
  logic op_write, op_all, instr_done, mem_req, mem_we, mem_ee, dbg_cmd_valid;
  logic [23:0] op_addr, mem_addr, ca_addr;
  logic [7:0] op_data, mem_wdata, ca_data;
  logic [6:0] dbg_cmd;
  logic [3:0] ca_fl;
  logic pres = 1'b0, locked = 1'b0, brownout_detector = 1'b1, sleep_req = 1'b0, sleep_idle = 1'b0;
  int n_fail = 0, compares = 0, n_ops = 0;
  always #12.5 clk = ~clk;
  nvs_sequencer #(.FL_CYC(20), .EE_CYC(10), .ERWR_CYC(20), .CHIP_ERASE_CMD_CYC(40)) dut (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_done(instr_done), .mem_req(mem_req), .mem_we(mem_we), .mem_ee(mem_ee),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wait(mem_wait), .cpu_halt(cpu_halt),
    .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd), .eeprom_preserve_fuse(pres),
    .device_locked(locked), .brownout_fuse_en(brownout_detector), .brownout_en(brownout_en),
    .sleep_req(sleep_req), .sleep_idle(sleep_idle), .nvm_clk_on(nvm_clk_on),
    .nvm_sleeping(nvm_sleeping), .irq(irq), .wake_req(wake_req),
    .flash_busy_flag(flash_busy_flag), .eeprom_busy_flag(eeprom_busy_flag),
    .op_start(op_start), .op_flash(op_flash), .op_erase(op_erase), .op_write(op_write),
    .op_all(op_all), .op_addr(op_addr), .op_mask(op_mask), .op_data(op_data));
  nvs_cpu_model u_cpu (.clk(clk), .mem_wait(mem_wait), .mem_req(mem_req), .mem_we(mem_we),
    .mem_ee(mem_ee), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .instr_done(instr_done),
    .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd));
  // ==========================================================
  // Operation capture and helpers
  always @(negedge clk) begin
    if (op_start === 1'b1) begin
      ca_addr = op_addr;
      ca_mask = op_mask;
      ca_data = op_data;
      ca_fl = {op_flash, op_erase, op_write, op_all};
      n_ops++;
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [23:0] align(input logic [23:0] a, input int lsb);
    return a & ~((24'h1 << lsb) - 24'h1);
  endfunction : align
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    logic done;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge clk);
      done = (pready === 1'b1);
      rd = prdata;
      rd_err = pslverr;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [6:0] c);
    apb(1'b1, IDX_KEY, {24'h0, KEY_CMD});
    apb(1'b1, IDX_CTRLA, {25'h0, c});
  endtask : cmd
  task automatic wait_idle(input int cyc);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (flash_busy_flag === 1'b0 && eeprom_busy_flag === 1'b0) break;
    end
    chk("busy time", i <= cyc && i + 8 >= cyc, 1'b1);
  endtask : wait_idle
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int k;
    logic [23:0] a;
    logic [7:0] d;
    logic [6:0] c;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, IDX_CTRLB, 32'h0);
    chk("ctrlb reset", rd, {24'h0, CTRLB_RST});
    apb(1'b0, 6'h03, 32'h0);
    chk("unmapped", rd_err, 1'b1);
    apb(1'b1, IDX_INTEN, 32'h3);
    for (k = 0; k < 6; k++) begin
      c = CMD_FLPG + 7'(k);
      a = 24'(rnd());
      cmd(c);
      u_cpu.store(1'b0, a, 8'h55);
      sleep_req <= 1'b1;
      sleep_idle <= k[0];
      repeat (2) @(negedge clk);
      chk("clk kept", nvm_clk_on, 1'b1);
      chk("fl kind", ca_fl, 4'b1100);
      chk("fl addr", ca_addr, align(a, 9 + k));
      wait_idle(18);
      @(negedge clk);
      chk("asleep", nvm_sleeping, 1'b1);
      chk("wake", wake_req, k[0]);
      sleep_req <= 1'b0;
      apb(1'b0, IDX_INTERRUPT_FLAG_REGISTER, 32'h0);
      chk("fl ready", rd[INT_FL_BIT], 1'b1);
      chk("irq set", irq, 1'b1);
      apb(1'b1, IDX_INTERRUPT_FLAG_REGISTER, 32'h3);
      @(negedge clk);
      chk("irq clr", irq, 1'b0);
      cmd(CMD_NONE);
    end
    // erase modes first, writes land in the erased block
    for (k = 0; k < 8; k++) begin
      c = (k < 6) ? CMD_EEBYTE + 7'(k) : CMD_EEWRITE + 7'(k - 6);
      a = (k < 6) ? 24'(rnd()) & 24'hff : (a & 24'he0) | (24'(rnd()) & 24'h1e);
      d = 8'(rnd());
      cmd(c);
      u_cpu.store(1'b1, a, d);
      u_cpu.store(1'b1, a ^ 24'h1, d);
      chk("ee stall", u_cpu.stall > 0, 1'b1);
      repeat (2) @(negedge clk);
      chk("ee kind", ca_fl, {1'b0, k != 6, k >= 6, 1'b0});
      chk("ee addr", ca_addr, align(a ^ 24'h1, (k < 6) ? k : 0));
      chk("ee data", ca_data, (k < 6) ? ERASED_BYTE : d);
      wait_idle(k == 7 ? 18 : 8);
      apb(1'b0, IDX_INTERRUPT_FLAG_REGISTER, 32'h0);
      chk("ee ready", rd[INT_EE_BIT], 1'b1);
      cmd(CMD_NONE);
    end
    cmd(CMD_FLPG);
    u_cpu.store(1'b0, 24'h1200, 8'h0);
    cmd(CMD_EEWRITE);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("collision", rd[6:4], ERR_COLLISION);
    wait_idle(11);
    cmd(CMD_NONE);
    cmd(CMD_EEWRITE);
    cmd(CMD_EEBYTE);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("sequence", rd[6:4], ERR_SEQUENCE);
    cmd(CMD_NONE);
    apb(1'b1, IDX_KEY, {24'h0, KEY_CMD});
    u_cpu.instr(5);
    apb(1'b1, IDX_CTRLA, {25'h0, CMD_EEWRITE});
    apb(1'b1, IDX_CTRLB, 32'hf);
    apb(1'b0, IDX_CTRLA, 32'h0);
    chk("late key", rd, 32'h0);
    apb(1'b0, IDX_CTRLB, 32'h0);
    chk("no key", rd, {24'h0, CTRLB_RST});
    cmd(CMD_CHIP);
    apb(1'b0, IDX_CTRLA, 32'h0);
    chk("cpu chip", rd, 32'h0);
    for (k = 0; k < 3; k++) u_cpu.store(1'b1, 24'h40 + 24'(3 * k), 8'(rnd()));
    k = n_ops;
    cmd(CMD_EEPAGE);
    repeat (2) @(negedge clk);
    chk("pg mask", ca_mask, 32'h49);
    chk("pg start", n_ops, k + 1);
    wait_idle(10);
    cmd(CMD_NONE);
    k = n_ops;
    cmd(CMD_EEPAGE);
    repeat (3) @(negedge clk);
    chk("pg cleared", n_ops, k);
    cmd(CMD_NONE);
    cmd(CMD_EEALL);
    repeat (2) @(negedge clk);
    chk("halt", cpu_halt, 1'b1);
    chk("all kind", {ca_fl, ca_data}, {4'b0101, ERASED_BYTE});
    wait_idle(38);
    @(negedge clk);
    chk("halt end", cpu_halt, 1'b0);
    cmd(CMD_NONE);
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      pres <= k[0];
      locked <= k[1];
      u_cpu.dbg(CMD_CHIP);
      repeat (2) @(negedge clk);
      chk("chip kind", ca_fl, 4'b1101);
      chk("chip ee", ca_mask[0], !(k[0] && !k[1]));
      chk("brownout", brownout_en, 1'b1);
      wait_idle(40);
    end
    cmd(CMD_FLPG);
    u_cpu.store(1'b0, 24'h400, 8'h0);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("abort", {flash_busy_flag, eeprom_busy_flag}, 2'b00);
    summarize();
  end
endmodule : tb_nvm_erase_write_sequencer
`default_nettype wire
